/* File: bfg_pkg.sv */
// Package for balancer fault gating: register map, fields, timing counts.
// Assumes a single 200 MHz clock domain and an APB register bus.
package bfg_pkg;
   localparam int          NCELL          = 6;
   localparam int          CLK_MHZ        = 200;
   // Comparator filter interval, 3 us least
   localparam int          FILT_NS        = 3000;
   localparam int          FILT_CYC       = (FILT_NS * CLK_MHZ + 999) / 1000;
   localparam logic [11:0] FILT_LAST      = 12'(FILT_CYC - 1);
   // Register byte offsets
   localparam logic [7:0]  OFS_CMD        = 8'h00;
   localparam logic [7:0]  OFS_CTRL       = 8'h04;
   localparam logic [7:0]  OFS_PRI_TON    = 8'h08;
   localparam logic [7:0]  OFS_SEC_TON    = 8'h0c;
   localparam logic [7:0]  OFS_STATUS     = 8'h10;
   localparam logic [7:0]  OFS_IRQ_STAT   = 8'h14;
   localparam logic [7:0]  OFS_IRQ_MASK   = 8'h18;
   // Control fields
   localparam int          CTRL_BOOST     = 0;
   localparam int          CTRL_PRI_DEF   = 1;
   localparam int          CTRL_SEC_DEF   = 2;
   // Interrupt status fields
   localparam int          IRQ_OV         = 0;
   localparam int          IRQ_OT         = 1;
   localparam int          IRQ_GD         = 2;
   localparam int          IRQ_PCLAMP     = 3;
   localparam int          IRQ_SCLAMP     = 4;
   localparam int          IRQ_W          = 5;
   // Reset values
   localparam logic [11:0] CMD_RST        = 12'h000;
   localparam logic [2:0]  CTRL_RST       = 3'h0;
   localparam logic [15:0] PRI_TON_RST    = 16'h05a0;
   localparam logic [15:0] SEC_TON_RST    = 16'h00f0;
   localparam logic [4:0]  IRQ_MASK_RST   = 5'h00;

   typedef enum logic [1:0] {
      BFG_IDLE = 2'b00,
      BFG_ON   = 2'b01,
      BFG_CUT  = 2'b11
   } bfg_phase_t;

   typedef struct packed {
      logic [NCELL-1:0] cell_gd;
      logic [NCELL-1:0] cell_ov;
      logic             next_gd;
      logic             over_temp;
      logic             por;
   } bfg_ind_t;

   typedef struct packed {
      logic [NCELL-1:0] pri;
      logic [NCELL-1:0] sec;
   } bfg_gate_t;
endpackage

/* File: bfg_gate.sv */
// Fault gating for six bidirectional cell balancers with on-time clamps.
// Assumes comparator indications arrive asynchronously from analog circuits.
`timescale 1ns/1ps
module bfg_gate
   import bfg_pkg::*;
(
   input  wire logic                 CLK,
   input  wire logic                 RST,
   input  wire logic [NCELL-1:0]     CELL_GD,
   input  wire logic [NCELL-1:0]     CELL_OV,
   input  wire logic                 NEXT_GD,
   input  wire logic                 OVER_TEMP,
   input  wire logic                 POR,
   input  wire logic [NCELL-1:0]     PRI_PEAK,
   input  wire logic [NCELL-1:0]     SEC_PEAK,
   input  wire logic [NCELL-1:0]     PRI_ZERO,
   input  wire logic [NCELL-1:0]     SEC_ZERO,
   input  wire logic                 PSEL,
   input  wire logic                 PENABLE,
   input  wire logic                 PWRITE,
   input  wire logic [7:0]           PADDR,
   input  wire logic [31:0]          PWDATA,
   output logic      [31:0]          PRDATA,
   output logic                      PREADY,
   output logic                      PSLVERR,
   output bfg_pkg::bfg_gate_t        GATE,
   output logic                      IRQ
);
   import bfg_pkg::*;

   // Two-stage synchronisers on analog indications and switch feedback
   localparam int SW = 2*NCELL + 3 + 4*NCELL;
   logic [SW-1:0]    sync1_ff;
   logic [SW-1:0]    sync2_ff;
   always_ff @(posedge CLK) begin
      sync1_ff <= {CELL_GD, CELL_OV, NEXT_GD, OVER_TEMP, POR,
                   PRI_PEAK, SEC_PEAK, PRI_ZERO, SEC_ZERO};
      sync2_ff <= sync1_ff;
   end

   bfg_ind_t         raw;
   logic [NCELL-1:0] pri_peak;
   logic [NCELL-1:0] sec_peak;
   logic [NCELL-1:0] pri_zero;
   logic [NCELL-1:0] sec_zero;
   assign {raw, pri_peak, sec_peak, pri_zero, sec_zero} = sync2_ff;

   // Stability filters on gate-drive and overvoltage comparators
   localparam int NF = 2*NCELL + 1;
   logic [NF-1:0]    filt_in;
   logic [NF-1:0]    filt_ff;
   logic [11:0]      fcnt_ff [NF];
   assign filt_in = {raw.cell_gd, raw.cell_ov, raw.next_gd};

   always_ff @(posedge CLK) begin
      for (int i = 0; i < NF; i++) begin
         if (RST) begin
            fcnt_ff[i] <= 12'h000;
            filt_ff[i] <= 1'b0;
         end else if (filt_in[i] == filt_ff[i]) begin
            fcnt_ff[i] <= 12'h000;
         end else if (fcnt_ff[i] == FILT_LAST) begin
            fcnt_ff[i] <= 12'h000;
            filt_ff[i] <= filt_in[i];
         end else begin
            fcnt_ff[i] <= fcnt_ff[i] + 12'h001;
         end
      end
   end

   logic [NCELL-1:0] gd_f;
   logic [NCELL-1:0] ov_f;
   logic             ngd_f;
   assign {gd_f, ov_f, ngd_f} = filt_ff;

   // Registers
   logic [11:0]      cmd_ff;
   logic [2:0]       ctrl_ff;
   logic [15:0]      pri_ton_ff;
   logic [15:0]      sec_ton_ff;
   logic [IRQ_W-1:0] irq_stat_ff;
   logic [IRQ_W-1:0] irq_mask_ff;

   logic             wr_acc;
   logic             rd_acc;
   logic             addr_ok;
   assign wr_acc = PSEL && PENABLE && PWRITE;
   assign rd_acc = PSEL && PENABLE && !PWRITE;

   function automatic logic mapped(input logic [7:0] a);
      return a == OFS_CMD || a == OFS_CTRL || a == OFS_PRI_TON || a == OFS_SEC_TON ||
             a == OFS_STATUS || a == OFS_IRQ_STAT || a == OFS_IRQ_MASK;
   endfunction
   assign addr_ok = mapped(PADDR);

   // Command: bits [5:0] discharge, [11:6] charge; cleared by power-on reset
   always_ff @(posedge CLK) begin
      if (RST || raw.por) begin
         cmd_ff <= CMD_RST;
      end else if (wr_acc && PADDR == OFS_CMD) begin
         cmd_ff <= PWDATA[11:0];
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         ctrl_ff    <= CTRL_RST;
         pri_ton_ff <= PRI_TON_RST;
         sec_ton_ff <= SEC_TON_RST;
         irq_mask_ff <= IRQ_MASK_RST;
      end else if (wr_acc) begin
         if (PADDR == OFS_CTRL) begin
            ctrl_ff <= PWDATA[2:0];
         end
         if (PADDR == OFS_PRI_TON) begin
            pri_ton_ff <= PWDATA[15:0];
         end
         if (PADDR == OFS_SEC_TON) begin
            sec_ton_ff <= PWDATA[15:0];
         end
         if (PADDR == OFS_IRQ_MASK) begin
            irq_mask_ff <= PWDATA[IRQ_W-1:0];
         end
      end
   end

   // Gate-drive enable per balancer
   logic [NCELL-1:0] gd_en;
   logic             fault_all;
   always_comb begin
      for (int i = 0; i < NCELL-1; i++) begin
         gd_en[i] = gd_f[i] && gd_f[i+1];
      end
      gd_en[NCELL-1] = gd_f[NCELL-1] && (ctrl_ff[CTRL_BOOST] || ngd_f);
   end
   assign fault_all = (|ov_f) || raw.over_temp || raw.por;

   logic [NCELL-1:0] run_dis;
   logic [NCELL-1:0] run_chg;
   assign run_dis = cmd_ff[5:0] & gd_en & {NCELL{!fault_all}};
   assign run_chg = cmd_ff[11:6] & gd_en & {NCELL{!fault_all}};

   // Switch sequencing per balancer with on-time clamp
   bfg_phase_t       ph_ff [NCELL];
   logic [15:0]      ton_ff [NCELL];
   logic [NCELL-1:0] pclamp_ev;
   logic [NCELL-1:0] sclamp_ev;
   logic [NCELL-1:0] gpri_ff;
   logic [NCELL-1:0] gsec_ff;

   always_ff @(posedge CLK) begin
      for (int i = 0; i < NCELL; i++) begin
         pclamp_ev[i] <= 1'b0;
         sclamp_ev[i] <= 1'b0;
         if (RST || !(run_dis[i] || run_chg[i])) begin
            ph_ff[i]   <= BFG_IDLE;
            ton_ff[i]  <= 16'h0000;
            gpri_ff[i] <= 1'b0;
            gsec_ff[i] <= 1'b0;
         end else begin
            case (ph_ff[i])
               BFG_IDLE: begin
                  ph_ff[i]   <= BFG_ON;
                  ton_ff[i]  <= 16'h0000;
                  gpri_ff[i] <= run_dis[i];
                  gsec_ff[i] <= !run_dis[i];
               end
               BFG_ON: begin
                  ton_ff[i] <= ton_ff[i] + 16'h0001;
                  if (run_dis[i] && (pri_peak[i] ||
                      (!ctrl_ff[CTRL_PRI_DEF] && ton_ff[i] >= pri_ton_ff))) begin
                     pclamp_ev[i] <= !pri_peak[i];
                     ph_ff[i]     <= BFG_CUT;
                     gpri_ff[i]   <= 1'b0;
                     gsec_ff[i]   <= 1'b1;
                  end else if (!run_dis[i] && (sec_peak[i] ||
                      (!ctrl_ff[CTRL_SEC_DEF] && ton_ff[i] >= sec_ton_ff))) begin
                     sclamp_ev[i] <= !sec_peak[i];
                     ph_ff[i]     <= BFG_CUT;
                     gsec_ff[i]   <= 1'b0;
                     gpri_ff[i]   <= 1'b1;
                  end
               end
               BFG_CUT: begin
                  if (run_dis[i] ? sec_zero[i] : pri_zero[i]) begin
                     ph_ff[i]   <= BFG_IDLE;
                     gpri_ff[i] <= 1'b0;
                     gsec_ff[i] <= 1'b0;
                  end
               end
               default: begin
                  ph_ff[i] <= BFG_IDLE;
               end
            endcase
         end
      end
   end
   assign GATE = '{pri: gpri_ff, sec: gsec_ff};

   // Interrupt status, write one to clear, set wins
   logic [IRQ_W-1:0] ev;
   logic [IRQ_W-1:0] wclr;
   logic             gd_loss;
   assign gd_loss = |((cmd_ff[5:0] | cmd_ff[11:6]) & ~gd_en);
   assign ev   = {|sclamp_ev, |pclamp_ev, gd_loss, raw.over_temp, |ov_f};
   assign wclr = (wr_acc && PADDR == OFS_IRQ_STAT) ? PWDATA[IRQ_W-1:0] : '0;
   always_ff @(posedge CLK) begin
      if (RST) begin
         irq_stat_ff <= '0;
      end else begin
         irq_stat_ff <= (irq_stat_ff & ~wclr) | ev;
      end
   end
   always_ff @(posedge CLK) begin
      if (RST) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(((irq_stat_ff & ~wclr) | ev) & irq_mask_ff);
      end
   end

   // APB answer: one access cycle, registered data
   logic [31:0] rd_mux;
   always_comb begin
      case (PADDR)
         OFS_CMD:      rd_mux = {20'h00000, cmd_ff};
         OFS_CTRL:     rd_mux = {29'h0, ctrl_ff};
         OFS_PRI_TON:  rd_mux = {16'h0000, pri_ton_ff};
         OFS_SEC_TON:  rd_mux = {16'h0000, sec_ton_ff};
         OFS_STATUS:   rd_mux = {18'h00000, raw.por, raw.over_temp, ov_f, gd_en};
         OFS_IRQ_STAT: rd_mux = {27'h0, irq_stat_ff};
         OFS_IRQ_MASK: rd_mux = {27'h0, irq_mask_ff};
         default:      rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h00000000;
      end else begin
         PREADY  <= PSEL && !PENABLE;
         PSLVERR <= PSEL && !PENABLE && !addr_ok;
         PRDATA  <= (PSEL && !PENABLE && !PWRITE) ? rd_mux : 32'h00000000;
      end
   end

   // Checks
   sequence s_ov_seen;
      (|ov_f) ##1 1'b1;
   endsequence
   chk_ov_stops_all: assert property (@(posedge CLK) disable iff (RST)
      s_ov_seen |-> (GATE == '0)) else $error("gate active during overvoltage");
   chk_ot_stops_all: assert property (@(posedge CLK) disable iff (RST)
      raw.over_temp |=> (GATE == '0)) else $error("gate active during overtemp");
   chk_por_clears: assert property (@(posedge CLK) disable iff (RST)
      raw.por |=> (cmd_ff == CMD_RST)) else $error("command kept through reset");
   chk_gd_gates: assert property (@(posedge CLK) disable iff (RST)
      !gd_en[0] |=> !(gpri_ff[0] || gsec_ff[0])) else $error("balancer without drive");
   chk_boost_six: assert property (@(posedge CLK) disable iff (RST)
      (ctrl_ff[CTRL_BOOST] && gd_f[NCELL-1]) |-> gd_en[NCELL-1])
      else $error("boost ignored");
   chk_cmd_kept: assert property (@(posedge CLK) disable iff (RST)
      (fault_all && !raw.por && !wr_acc) |=> $stable(cmd_ff)) else $error("command lost");
   chk_filt_stable: assert property (@(posedge CLK) disable iff (RST)
      $changed(filt_ff) |-> (((filt_ff ^ $past(filt_ff)) & ($past(filt_in, 2) ^ filt_ff)) == '0))
      else $error("filter too early");
   chk_pri_clamp: assert property (@(posedge CLK) disable iff (RST)
      (ph_ff[0] == BFG_ON && gpri_ff[0] && !ctrl_ff[CTRL_PRI_DEF] && run_dis[0] &&
       ton_ff[0] >= pri_ton_ff) |=> !gpri_ff[0]) else $error("primary clamp missed");
   chk_run_cond: assert property (@(posedge CLK) disable iff (RST)
      (gpri_ff[1] || gsec_ff[1]) |-> $past(run_dis[1] || run_chg[1]))
      else $error("drive without command");

   // Bus answer checks
   sequence s_apb_setup;
      PSEL && !PENABLE;
   endsequence
   sequence s_bad_setup;
      s_apb_setup ##0 !addr_ok;
   endsequence
   chk_apb_ready: assert property (@(posedge CLK) disable iff (RST)
      s_apb_setup |=> PREADY) else $error("no ready after setup");
   chk_ready_pulse: assert property (@(posedge CLK) disable iff (RST)
      PREADY |-> $past(PSEL && !PENABLE)) else $error("ready without setup");
   chk_apb_error: assert property (@(posedge CLK) disable iff (RST)
      s_bad_setup |=> PSLVERR) else $error("unmapped address accepted");
   chk_rd_answer: assert property (@(posedge CLK) disable iff (RST)
      rd_acc |-> (PRDATA == $past(rd_mux))) else $error("read data wrong");
   chk_wr_lands: assert property (@(posedge CLK) disable iff (RST)
      (wr_acc && PADDR == OFS_CTRL) |=> (ctrl_ff == $past(PWDATA[2:0])))
      else $error("control write lost");

   // Filter and gating checks
   chk_filt_count: assert property (@(posedge CLK) disable iff (RST)
      $changed(filt_ff[0]) |-> ($past(fcnt_ff[0]) == FILT_LAST))
      else $error("next cell filter skipped");
   chk_filt_ov_count: assert property (@(posedge CLK) disable iff (RST)
      $changed(filt_ff[5]) |-> ($past(fcnt_ff[5]) == FILT_LAST))
      else $error("overvoltage filter skipped");
   sequence s_sec_over;
      ph_ff[3] == BFG_ON && gsec_ff[3] && !ctrl_ff[CTRL_SEC_DEF] && !run_dis[3] &&
      ton_ff[3] >= sec_ton_ff;
   endsequence
   chk_sec_clamp: assert property (@(posedge CLK) disable iff (RST)
      s_sec_over |=> !gsec_ff[3]) else $error("secondary clamp missed");
   chk_pri_defeat: assert property (@(posedge CLK) disable iff (RST)
      (ph_ff[0] == BFG_ON && gpri_ff[0] && ctrl_ff[CTRL_PRI_DEF] && run_dis[0] &&
       !pri_peak[0]) |=> gpri_ff[0]) else $error("primary cut while defeated");
   chk_six_nboost: assert property (@(posedge CLK) disable iff (RST)
      (!ctrl_ff[CTRL_BOOST] && !ngd_f) |-> !gd_en[NCELL-1]) else $error("next cell ignored");
   chk_gd_local: assert property (@(posedge CLK) disable iff (RST)
      (ph_ff[3] == BFG_IDLE && run_chg[3] && !run_dis[3]) |=> gsec_ff[3])
      else $error("healthy balancer held off");
   chk_por_gate: assert property (@(posedge CLK) disable iff (RST)
      raw.por |=> (GATE == '0)) else $error("gate active during reset");

   // Interrupt checks
   chk_irq_level: assert property (@(posedge CLK) disable iff (RST)
      $stable(irq_mask_ff) |-> (IRQ == |(irq_stat_ff & irq_mask_ff)))
      else $error("interrupt level wrong");
   chk_ov_sets: assert property (@(posedge CLK) disable iff (RST)
      (|ov_f) |=> irq_stat_ff[IRQ_OV]) else $error("overvoltage flag lost");
   chk_ot_sets: assert property (@(posedge CLK) disable iff (RST)
      raw.over_temp |=> irq_stat_ff[IRQ_OT]) else $error("overtemp flag lost");
   chk_gd_sets: assert property (@(posedge CLK) disable iff (RST)
      gd_loss |=> irq_stat_ff[IRQ_GD]) else $error("gate drive flag lost");
   chk_pclamp_sets: assert property (@(posedge CLK) disable iff (RST)
      (|pclamp_ev) |=> irq_stat_ff[IRQ_PCLAMP]) else $error("primary clamp flag lost");
   chk_sclamp_sets: assert property (@(posedge CLK) disable iff (RST)
      (|sclamp_ev) |=> irq_stat_ff[IRQ_SCLAMP]) else $error("secondary clamp flag lost");
endmodule

/* File: bfg_cells.sv */
// Model of the cells, transformer windings and power switches.
// Assumes gate levels arrive on CLK; sense levels answer on CLK.
`timescale 1ns/1ps
module bfg_cells
   import bfg_pkg::*;
#(
   parameter int RAMP = 8
)(
   input  wire logic               CLK,
   input  wire bfg_pkg::bfg_gate_t GATE,
   input  wire logic               SHORT,
   output logic [NCELL-1:0]        PRI_PEAK,
   output logic [NCELL-1:0]        SEC_PEAK,
   output logic [NCELL-1:0]        PRI_ZERO,
   output logic [NCELL-1:0]        SEC_ZERO
);
   int pc [NCELL];
   int sc [NCELL];
   // Winding on-time counters
   always_ff @(posedge CLK) begin
      for (int i = 0; i < NCELL; i++) begin
         pc[i] <= GATE.pri[i] ? pc[i] + 1 : 0;
         sc[i] <= GATE.sec[i] ? sc[i] + 1 : 0;
      end
   end
   // Shorted sense never reports peak
   always_comb begin
      for (int i = 0; i < NCELL; i++) begin
         PRI_PEAK[i] = !SHORT && pc[i] >= RAMP;
         SEC_PEAK[i] = !SHORT && sc[i] >= RAMP;
         PRI_ZERO[i] = pc[i] >= RAMP;
         SEC_ZERO[i] = sc[i] >= RAMP;
      end
   end
endmodule

/* File: balancer_fault_gating_tb_top.sv */
// Self-checking bench for the balancer fault gating block.
// Assumes the cell model answers the switch gates on the same clock.
`timescale 1ns/1ps
module balancer_fault_gating_tb_top;
   import bfg_pkg::*;
   logic             clk, rst, psel, penable, pwrite, next_gd, ot, por, short;
   logic [NCELL-1:0] cell_gd, cell_ov, pp, sp, pz, sz;
   logic [7:0]       paddr;
   logic [31:0]      pwdata, prdata, rd;
   logic             pready, pslverr, irq, err, on;
   bfg_gate_t        gate;
   int               n_mismatch, n_checks, len;
   bfg_gate bfg_gate_inst (.CLK(clk), .RST(rst), .CELL_GD(cell_gd), .CELL_OV(cell_ov),
      .NEXT_GD(next_gd), .OVER_TEMP(ot), .POR(por), .PRI_PEAK(pp), .SEC_PEAK(sp),
      .PRI_ZERO(pz), .SEC_ZERO(sz), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .GATE(gate), .IRQ(irq));
   bfg_cells bfg_cells_inst (.CLK(clk), .GATE(gate), .SHORT(short), .PRI_PEAK(pp),
      .SEC_PEAK(sp), .PRI_ZERO(pz), .SEC_ZERO(sz));
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic tmo();
      n_mismatch++;
      $display("MISMATCH t=%0t wait ran out", $time);
      end_of_test();
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (k == 20) tmo();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic act(input int i);
      on = 0;
      repeat (200) begin
         @(posedge clk);
         if (gate.pri[i] === 1'b1 || gate.sec[i] === 1'b1) on = 1;
      end
   endtask
   task automatic meas(input logic p, input int i);
      int k;
      for (k = 0; k < 300 && (p ? gate.pri[i] : gate.sec[i]) === 1'b1; k++) wt(1);
      for (k = 0; k < 300 && (p ? gate.pri[i] : gate.sec[i]) !== 1'b1; k++) wt(1);
      if (k == 300) tmo();
      for (len = 0; len < 100 && (p ? gate.pri[i] : gate.sec[i]) === 1'b1; len++) wt(1);
   endtask
   task automatic t_reset();
      chk(gate, 0);
      apb(0, OFS_CMD, 0);
      chk(rd, 0);
      apb(0, OFS_PRI_TON, 0);
      chk(rd, 32'h5a0);
      apb(0, OFS_SEC_TON, 0);
      chk(rd, 32'hf0);
      apb(0, 8'h1c, 0);
      chk(err, 1);
      wt(700);
      apb(0, OFS_STATUS, 0);
      chk(rd, 32'h1f);
      apb(1, OFS_CTRL, 32'h1);
      apb(0, OFS_STATUS, 0);
      chk(rd, 32'h3f);
      apb(1, OFS_CTRL, 32'h0);
      next_gd <= 1'b1;
      wt(700);
      apb(0, OFS_STATUS, 0);
      chk(rd, 32'h3f);
      apb(1, OFS_CTRL, 32'h1);
      apb(1, OFS_IRQ_MASK, 32'h1f);
      $display("reset and boost done");
   endtask
   task automatic t_run();
      apb(1, OFS_CMD, 32'h201);
      act(0);
      chk(on, 1);
      cell_gd <= 6'h3d;
      act(0);
      chk(on, 1);
      wt(600);
      apb(0, OFS_STATUS, 0);
      chk(rd, 32'h3c);
      act(0);
      chk(on, 0);
      act(3);
      chk(on, 1);
      chk(irq, 1);
      cell_gd <= 6'h3f;
      wt(700);
      act(0);
      chk(on, 1);
      apb(1, OFS_IRQ_STAT, 32'h1f);
      apb(0, OFS_IRQ_STAT, 0);
      chk(rd, 0);
      chk(irq, 0);
      $display("gate drive done");
   endtask
   task automatic t_ov();
      cell_ov <= 6'h10;
      wt(700);
      act(0);
      chk(on, 0);
      act(3);
      chk(on, 0);
      apb(0, OFS_STATUS, 0);
      chk(rd, 32'h43f);
      apb(0, OFS_IRQ_STAT, 0);
      chk(rd, 32'h1);
      chk(irq, 1);
      apb(1, OFS_IRQ_MASK, 32'h0);
      wt(2);
      chk(irq, 0);
      cell_ov <= 6'h00;
      wt(700);
      act(3);
      chk(on, 1);
      apb(1, OFS_IRQ_STAT, 32'h1f);
      apb(1, OFS_IRQ_MASK, 32'h1f);
      ot <= 1'b1;
      wt(10);
      act(3);
      chk(on, 0);
      chk(irq, 1);
      apb(0, OFS_STATUS, 0);
      chk(rd, 32'h103f);
      ot <= 1'b0;
      wt(10);
      act(3);
      chk(on, 1);
      apb(1, OFS_IRQ_STAT, 32'h1f);
      $display("overvoltage and heat done");
   endtask
   task automatic t_clamp();
      short <= 1'b1;
      apb(1, OFS_PRI_TON, 32'd20);
      apb(1, OFS_SEC_TON, 32'd10);
      meas(1, 0);
      chk(len inside {[20:22]}, 1);
      meas(0, 3);
      chk(len inside {[10:12]}, 1);
      apb(0, OFS_IRQ_STAT, 0);
      chk(rd & 32'h18, 32'h18);
      chk(irq, 1);
      apb(1, OFS_CTRL, 32'h7);
      meas(1, 0);
      chk(len, 100);
      meas(0, 3);
      chk(len, 100);
      short <= 1'b0;
      apb(1, OFS_CTRL, 32'h1);
      por <= 1'b1;
      wt(10);
      chk(gate, 0);
      por <= 1'b0;
      wt(20);
      apb(0, OFS_CMD, 0);
      chk(rd, 0);
      $display("clamp and power reset done");
   endtask
   initial begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {next_gd, ot, por, short, cell_ov} = '0;
      cell_gd = 6'h3f;
      n_mismatch = 0;
      n_checks = 0;
      rst = 1'b1;
      wt(12);
      rst <= 1'b0;
      t_reset();
      t_run();
      t_ov();
      t_clamp();
      end_of_test();
   end
endmodule
